// ---- fpu_flag_set_shadow_save.v ----
`timescale 1ns/100ps
`include "fpu_flag_defs.vh"

// Operation
// RULE1: flag-set uses an 11-bit mask; unselected flags keep their value.
// RULE2: mask bit 9 rounding mode, bits 6..0 test..overflow; 10,8,7 reserved.
// RULE3: an 11-bit value field gives the new state of each selected flag.
// RULE4: save copies eight working registers and status to shadow, plus flag update.
// RULE5: shadow status holds the flags from before the masked update.
// RULE6: save sets the shadow mode flag to one.
// RULE7: save and flag-set each complete in one cycle.
// RULE8: software keeps save out of pipelined delay slots.
// RULE9: software keeps flag-set out of pipelined delay slots.
// RULE10: software uses save only in non-interruptible handlers.
// RULE11: save recognised by fixed top ten bits of low word, then mask bits.
// RULE12: flag-set low word differs from save only in bit 6, zero.
// RULE13: reserved mask and value positions leave status bits unchanged.
// RULE14: working registers keep their contents after a save.
module fpu_flag_set_shadow_save #(
   parameter NUM_REGS = 8,
   parameter DATA_W   = 32,
   parameter ADR_W    = 8
) (
   input  wire              I_CLK,
   input  wire              I_SRST,
   input  wire              I_WB_CYC,
   input  wire              I_WB_STB,
   input  wire              I_WB_WE,
   input  wire [ADR_W-1:0]  I_WB_ADR,
   input  wire [3:0]        I_WB_SEL,
   input  wire [DATA_W-1:0] I_WB_DAT,
   output reg  [DATA_W-1:0] O_WB_DAT,
   output reg               O_WB_ACK,
   output reg  [`STATUS_W-1:0] O_STATUS
);

   // ****************************************
   // helpers
   // ****************************************
   function [2:0] region;
      input [ADR_W-1:0] adr;
      begin
         if (adr == `ADR_OP_LOW)
            region = `RG_OP_LOW;
         else if (adr == `ADR_OP_HIGH)
            region = `RG_OP_HIGH;
         else if (adr == `ADR_STATUS)
            region = `RG_STATUS;
         else if (adr == `ADR_SHADOW_STAT)
            region = `RG_SHADOW_STAT;
         else if (adr == `ADR_LAST_OP)
            region = `RG_LAST_OP;
         else if ((adr & `ADR_BANK_MASK) == `ADR_WORK_BASE && adr[1:0] == 2'h0)
            region = `RG_WORK;
         else if ((adr & `ADR_BANK_MASK) == `ADR_SHADOW_BASE && adr[1:0] == 2'h0)
            region = `RG_SHADOW;
         else
            region = `RG_NONE;
      end
   endfunction

   // byte-lane merge, used for every writable word
   function [DATA_W-1:0] merge;
      input [DATA_W-1:0] old;
      input [DATA_W-1:0] upd;
      input [3:0]        sel;
      integer            b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b])
               merge[b*8 +: 8] = upd[b*8 +: 8];
         end
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   reg  [DATA_W-1:0]         work   [0:NUM_REGS-1];
   reg  [DATA_W-1:0]         shadow [0:NUM_REGS-1];
   reg  [`STATUS_W-1:0]      status;
   reg  [`STATUS_W-1:0]      shadow_status;
   reg  [`OPC_LOW_W-1:0]     op_low;
   reg  [`OPC_LOW_W-1:0]     op_high;
   reg  [1:0]                last_op;

   wire                      req;
   wire                      wr;
   wire [2:0]                rg;
   wire [`ADR_IDX_MSB-`ADR_IDX_LSB:0] idx;
   wire [DATA_W-1:0]         op_word;
   wire [`OPC_LOW_W-1:0]     next_high;
   wire                      is_save;
   wire                      is_set_status_flags_op;
   wire [`FLAG_W-1:0]        mask;
   wire [`FLAG_W-1:0]        value;
   wire                      exec;
   wire [`STATUS_W-1:0]      next_status;
   reg  [DATA_W-1:0]         next_rdata;
   wire [DATA_W-1:0]         low_word;
   wire [DATA_W-1:0]         stat_word;
   wire [`OPC_LOW_W-1:0]     next_low;
   wire [`STATUS_W-1:0]      next_wr_status;

   // new request only; ack drops for one cycle between transfers
   assign req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
   assign wr  = req & I_WB_WE;
   assign rg  = region(I_WB_ADR);
   assign idx = I_WB_ADR[`ADR_IDX_MSB:`ADR_IDX_LSB];

   // high word write issues the op, using the lanes it carries
   assign op_word   = merge({{(DATA_W-`OPC_LOW_W){1'b0}}, op_high}, I_WB_DAT, I_WB_SEL);
   assign next_high = op_word[`OPC_LOW_W-1:0];
   assign exec      = wr & (rg == `RG_OP_HIGH);

   // merged words are full bus width; keep only the register's own bits
   assign low_word       = merge({{(DATA_W-`OPC_LOW_W){1'b0}}, op_low}, I_WB_DAT, I_WB_SEL);
   assign next_low       = low_word[`OPC_LOW_W-1:0];
   // direct write lets software leave shadow mode; reserved stay zero
   assign stat_word      = merge({{(DATA_W-`STATUS_W){1'b0}}, status}, I_WB_DAT, I_WB_SEL)
                           & {{(DATA_W-`STATUS_W){1'b0}}, 1'b1, `FLAG_WRITABLE};
   assign next_wr_status = stat_word[`STATUS_W-1:0];

   // ****************************************
   // decode and flag update
   // ****************************************
   fpu_op_decoder u_decoder (
      .i_low       (op_low),
      .i_high      (next_high),
      .o_is_save   (is_save),
      .o_is_set_status_flags_op (is_set_status_flags_op),
      .o_mask      (mask),
      .o_value     (value)
   );

   fpu_flag_update u_update (
      .i_status     (status),
      .i_mask       (mask),
      .i_value      (value),
      .i_set_shadow (is_save),
      .o_status     (next_status)
   );

   // ****************************************
   // working and shadow registers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g = g + 1) begin : g_regs
         always @(posedge I_CLK) begin
            if (I_SRST) begin
               work[g]   <= `REG_RESET;
               shadow[g] <= `REG_RESET;
            end else begin
               // RULE14: save leaves working copy alone
               if (wr && rg == `RG_WORK && idx == g)
                  work[g] <= merge(work[g], I_WB_DAT, I_WB_SEL);
               // RULE4: copy working set on save
               if (exec && is_save)
                  shadow[g] <= work[g];
            end
         end
      end
   endgenerate

   // ****************************************
   // status, opcode words, last op
   // ****************************************
   always @(posedge I_CLK) begin
      if (I_SRST) begin
         status        <= `STATUS_RESET;
         shadow_status <= `STATUS_RESET;
         op_low        <= {`OPC_LOW_W{1'b0}};
         op_high       <= {`OPC_LOW_W{1'b0}};
         last_op       <= `LAST_NONE;
         O_STATUS      <= `STATUS_RESET;
      end else begin
         if (wr && rg == `RG_OP_LOW)
            op_low <= next_low;
         if (exec) begin
            op_high <= next_high;
            // RULE7: whole op lands on one edge
            if (is_save) begin
               // RULE5: shadow takes pre-update flags
               shadow_status <= status;
               status        <= next_status;
               O_STATUS      <= next_status;
               last_op       <= `LAST_SAVE;
            end else if (is_set_status_flags_op) begin
               status   <= next_status;
               O_STATUS <= next_status;
               last_op  <= `LAST_SET_STATUS_FLAGS_OP;
            end else begin
               last_op <= `LAST_UNKNOWN;
            end
         end else if (wr && rg == `RG_STATUS) begin
            status   <= next_wr_status;
            O_STATUS <= next_wr_status;
         end
      end
   end

   // ****************************************
   // bus read mux and ack
   // ****************************************
   always @* begin
      next_rdata = `WORD_ZERO;
      if (rg == `RG_OP_LOW)
         next_rdata = {{(DATA_W-`OPC_LOW_W){1'b0}}, op_low};
      else if (rg == `RG_OP_HIGH)
         next_rdata = {{(DATA_W-`OPC_LOW_W){1'b0}}, op_high};
      else if (rg == `RG_STATUS)
         next_rdata = {{(DATA_W-`STATUS_W){1'b0}}, status};
      else if (rg == `RG_SHADOW_STAT)
         next_rdata = {{(DATA_W-`STATUS_W){1'b0}}, shadow_status};
      else if (rg == `RG_LAST_OP)
         next_rdata = {{(DATA_W-2){1'b0}}, last_op};
      else if (rg == `RG_WORK)
         next_rdata = work[idx];
      else if (rg == `RG_SHADOW)
         next_rdata = shadow[idx];
   end

   // unmapped addresses still ack, reading zero, so the bus never hangs
   always @(posedge I_CLK) begin
      if (I_SRST) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= `WORD_ZERO;
      end else begin
         O_WB_ACK <= req;
         if (req && !I_WB_WE)
            O_WB_DAT <= next_rdata;
      end
   end

endmodule // fpu_flag_set_shadow_save

// ---- fpu_flag_defs.vh ----
`ifndef FPU_FLAG_DEFS_VH
`define FPU_FLAG_DEFS_VH

// ****************************************
// instruction encoding
// ****************************************
`define OPC_LOW_W        16
`define OPC_FIXED_MSB    15
`define OPC_FIXED_LSB    6
`define OPC_SAVE_FIXED   10'h399
`define OPC_SET_STATUS_FLAGS_OP_FIXED 10'h398
`define OPC_LO_MASK_MSB  5
`define OPC_HI_MASK_MSB  15
`define OPC_HI_MASK_LSB  11
`define OPC_HI_VAL_MSB   10

// ****************************************
// flag field and status layout
// ****************************************
`define FLAG_W           11
`define FLAG_WRITABLE    11'h27f
`define STATUS_W         12
`define STATUS_SHADOW    11
`define STATUS_RESET     12'h000

// ****************************************
// register map (byte addresses)
// ****************************************
`define ADR_OP_LOW       8'h00
`define ADR_OP_HIGH      8'h04
`define ADR_STATUS       8'h08
`define ADR_SHADOW_STAT  8'h0c
`define ADR_LAST_OP      8'h10
`define ADR_WORK_BASE    8'h20
`define ADR_SHADOW_BASE  8'h40
`define ADR_BANK_MASK    8'he0
`define ADR_IDX_MSB      4
`define ADR_IDX_LSB      2

// ****************************************
// decode regions and last-op codes
// ****************************************
`define RG_NONE          3'h0
`define RG_OP_LOW        3'h1
`define RG_OP_HIGH       3'h2
`define RG_STATUS        3'h3
`define RG_SHADOW_STAT   3'h4
`define RG_LAST_OP       3'h5
`define RG_WORK          3'h6
`define RG_SHADOW        3'h7

`define LAST_NONE        2'h0
`define LAST_SET_STATUS_FLAGS_OP      2'h1
`define LAST_SAVE        2'h2
`define LAST_UNKNOWN     2'h3

`define WORD_ZERO        32'h0000_0000
`define REG_RESET        32'h0000_0000

`endif

// ---- fpu_op_decoder.v ----
`timescale 1ns/100ps
`include "fpu_flag_defs.vh"

module fpu_op_decoder (
   input  wire [`OPC_LOW_W-1:0] i_low,
   input  wire [`OPC_LOW_W-1:0] i_high,
   output wire                  o_is_save,
   output wire                  o_is_set_status_flags_op,
   output wire [`FLAG_W-1:0]    o_mask,
   output wire [`FLAG_W-1:0]    o_value
);

   wire [`OPC_FIXED_MSB-`OPC_FIXED_LSB:0] fixed;

   assign fixed       = i_low[`OPC_FIXED_MSB:`OPC_FIXED_LSB];
   // RULE11: save opcode match
   assign o_is_save   = (fixed == `OPC_SAVE_FIXED);
   // RULE12: flag-set opcode match
   assign o_is_set_status_flags_op = (fixed == `OPC_SET_STATUS_FLAGS_OP_FIXED);
   // RULE11: six mask bits low, five high
   assign o_mask      = {i_low[`OPC_LO_MASK_MSB:0], i_high[`OPC_HI_MASK_MSB:`OPC_HI_MASK_LSB]};
   // RULE3: value field
   assign o_value     = i_high[`OPC_HI_VAL_MSB:0];

endmodule // fpu_op_decoder

// ---- fpu_flag_update.v ----
`timescale 1ns/100ps
`include "fpu_flag_defs.vh"

module fpu_flag_update (
   input  wire [`STATUS_W-1:0] i_status,
   input  wire [`FLAG_W-1:0]   i_mask,
   input  wire [`FLAG_W-1:0]   i_value,
   input  wire                 i_set_shadow,
   output wire [`STATUS_W-1:0] o_status
);

   wire [`FLAG_W-1:0] sel;

   // RULE13: reserved positions dropped
   assign sel = i_mask & `FLAG_WRITABLE;

   // RULE1: masked flags take value, rest hold
   // RULE2: mask bit n drives status bit n
   assign o_status[`FLAG_W-1:0] = (i_status[`FLAG_W-1:0] & ~sel) | (i_value & sel);
   // RULE6: save raises shadow mode
   assign o_status[`STATUS_SHADOW] = i_status[`STATUS_SHADOW] | i_set_shadow;

endmodule // fpu_flag_update

// ---- fpu_flag_sva.sv ----
`timescale 1ns/100ps
`include "fpu_flag_defs.vh"

module fpu_flag_sva #(
   parameter DATA_W = 32,
   parameter ADR_W  = 8
) (
   input wire                  I_CLK,
   input wire                  I_SRST,
   input wire                  I_WB_CYC,
   input wire                  I_WB_STB,
   input wire                  I_WB_WE,
   input wire [ADR_W-1:0]      I_WB_ADR,
   input wire [3:0]            I_WB_SEL,
   input wire [DATA_W-1:0]     I_WB_DAT,
   input wire [DATA_W-1:0]     O_WB_DAT,
   input wire                  O_WB_ACK,
   input wire [`STATUS_W-1:0]  O_STATUS
);
   // ****************************************
   // opcode tracking
   // ****************************************
   reg  [15:0] op_low;
   wire        take    = I_WB_CYC && I_WB_STB && !O_WB_ACK;
   wire        op_wr   = take && I_WB_WE && I_WB_ADR == `ADR_OP_HIGH && I_WB_SEL[1:0] == 2'h3;
   wire        is_save = op_low[15:6] == `OPC_SAVE_FIXED;
   wire        is_set  = op_low[15:6] == `OPC_SET_STATUS_FLAGS_OP_FIXED;
   // reserved lanes dropped here so the expectation never depends on them
   wire [10:0] mask    = {op_low[5:0], I_WB_DAT[15:11]} & `FLAG_WRITABLE;
   wire [10:0] next_flags = (O_STATUS[10:0] & ~mask) | (I_WB_DAT[10:0] & mask);

   always @(posedge I_CLK) begin
      if (I_SRST) begin
         op_low <= 16'h0000;
      end else if (take && I_WB_WE && I_WB_ADR == `ADR_OP_LOW) begin
         if (I_WB_SEL[0]) op_low[7:0] <= I_WB_DAT[7:0];
         if (I_WB_SEL[1]) op_low[15:8] <= I_WB_DAT[15:8];
      end
   end

   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_SRST);

   // ****************************************
   // checks
   // ****************************************
   ack_follows_req_a: assert property (take |=> O_WB_ACK)
      else $error("ack missing one cycle after request");
   ack_single_a: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack longer than one cycle");
   flag_update_a: assert property (op_wr && (is_save || is_set) |=> O_STATUS[10:0] == $past(next_flags))
      else $error("masked flag update wrong");
   save_mode_set_a: assert property (op_wr && is_save |=> O_STATUS[11])
      else $error("save left shadow mode clear");
   set_status_flags_op_keeps_mode_a: assert property (op_wr && is_set |=> $stable(O_STATUS[11]))
      else $error("flag set touched shadow mode");
   unknown_op_a: assert property (op_wr && !is_save && !is_set |=> $stable(O_STATUS))
      else $error("unknown opcode changed status");
   reserved_zero_a: assert property (O_STATUS[10] == 1'b0 && O_STATUS[8:7] == 2'h0)
      else $error("reserved status bit set");
   status_quiet_a: assert property ($changed(O_STATUS) |-> $past(take && I_WB_WE))
      else $error("status changed without a write");
endmodule // fpu_flag_sva

bind fpu_flag_set_shadow_save fpu_flag_sva #(.DATA_W(DATA_W), .ADR_W(ADR_W)) u_sva (
   .I_CLK(I_CLK), .I_SRST(I_SRST), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE),
   .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT),
   .O_WB_ACK(O_WB_ACK), .O_STATUS(O_STATUS));

// ---- fpu_flag_set_shadow_save_tb.sv ----
`timescale 1ns/100ps
`include "fpu_flag_defs.vh"

module fpu_flag_set_shadow_save_tb;
   reg         clk = 1'b0;
   reg         srst = 1'b1;
   reg         cyc = 1'b0;
   reg         stb = 1'b0;
   reg         we = 1'b0;
   reg  [7:0]  adr = 8'h00;
   reg  [3:0]  sel = 4'h0;
   reg  [31:0] dat = 32'h0000_0000;
   wire [31:0] rdat;
   wire        ack;
   wire [11:0] status;
   reg  [31:0] q;
   reg  [11:0] exp_st;
   reg  [11:0] exp_sh;
   integer     mismatches = 0;
   integer     n_checks = 0;
   integer     i;

   always #4 clk = ~clk;

   fpu_flag_set_shadow_save DUT (.I_CLK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat),
      .O_WB_ACK(ack), .O_STATUS(status));

   // ****************************************
   // bus and compare tasks
   // ****************************************
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_checks, mismatches);
         if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask

   task chk_rd(input [31:0] got, input [31:0] want);
      begin
         n_checks = n_checks + 1;
         if (got !== want) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: read %h expected %h", $time, got, want);
         end
      end
   endtask

   task chk_st(input [11:0] want);
      begin
         n_checks = n_checks + 1;
         if (status !== want) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: status %h expected %h", $time, status, want);
         end
      end
   endtask

   // no cycle count assumed for ack; the watchdog bounds the wait
   task wb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
         @(posedge clk);
         while (ack !== 1'b1) @(posedge clk);
         q = rdat;
         cyc <= 1'b0; stb <= 1'b0;
      end
   endtask

   task rd(input [7:0] a, input [31:0] want);
      begin
         wb(1'b0, a, 32'h0000_0000);
         chk_rd(q, want);
      end
   endtask

   // expectation follows the rules: reserved lanes never reach the status
   task op(input sv, input [10:0] m, input [10:0] v);
      reg [10:0] mm;
      begin
         mm = m & `FLAG_WRITABLE;
         // save only after prior op done
         // flag-set only after prior op done
         wb(1'b1, `ADR_OP_LOW, {16'h0000, sv ? `OPC_SAVE_FIXED : `OPC_SET_STATUS_FLAGS_OP_FIXED, m[10:5]});
         wb(1'b1, `ADR_OP_HIGH, {16'h0000, m[4:0], v});
         if (sv) exp_sh = exp_st;
         exp_st[10:0] = (exp_st[10:0] & ~mm) | (v & mm);
         if (sv) exp_st[11] = 1'b1;
      end
   endtask

   function [31:0] wpat(input integer n);
      wpat = 32'h1357_9bd0 + n;
   endfunction

   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      exp_st = 12'h000;
      exp_sh = 12'h000;
      for (i = 0; i < 8; i = i + 1) wb(1'b1, `ADR_WORK_BASE + {i[2:0], 2'b00}, wpat(i));
      for (i = 0; i < 11; i = i + 1) begin
         op(1'b0, 11'h001 << i, 11'h7ff);
         chk_st(exp_st);
      end
      rd(`ADR_LAST_OP, 32'h0000_0001);
      op(1'b0, 11'h7ff, 11'h50a);
      chk_st(exp_st);
      op(1'b0, 11'h0c3, 11'h041);
      chk_st(exp_st);
      $display("test flag set done");
      op(1'b1, 11'h200, 11'h200);
      chk_st(exp_st);
      rd(`ADR_SHADOW_STAT, {20'h00000, exp_sh});
      for (i = 0; i < 8; i = i + 1) begin
         rd(`ADR_SHADOW_BASE + {i[2:0], 2'b00}, wpat(i));
         rd(`ADR_WORK_BASE + {i[2:0], 2'b00}, wpat(i));
      end
      rd(`ADR_LAST_OP, 32'h0000_0002);
      $display("test save done");
      wb(1'b1, `ADR_OP_LOW, 32'h0000_0000);
      wb(1'b1, `ADR_OP_HIGH, 32'h0000_ffff);
      chk_st(exp_st);
      rd(`ADR_LAST_OP, 32'h0000_0003);
      op(1'b0, 11'h001, 11'h000);
      chk_st(exp_st);
      op(1'b1, 11'h000, 11'h000);
      rd(`ADR_SHADOW_STAT, {20'h00000, exp_sh});
      $display("test unknown and resave done");
      wb(1'b1, `ADR_STATUS, 32'hffff_ffff);
      exp_st = 12'ha7f;
      chk_st(exp_st);
      rd(`ADR_STATUS, {20'h00000, exp_st});
      wb(1'b1, `ADR_STATUS, 32'h0000_0000);
      exp_st = 12'h000;
      chk_st(exp_st);
      op(1'b1, 11'h7ff, 11'h7ff);
      chk_st(exp_st);
      rd(`ADR_SHADOW_STAT, {20'h00000, exp_sh});
      rd(`ADR_OP_LOW, {16'h0000, `OPC_SAVE_FIXED, 6'h3f});
      rd(`ADR_OP_HIGH, 32'h0000_ffff);
      $display("test status write done");
      report_and_stop;
   end

   initial begin
      repeat (4000) @(posedge clk);
      mismatches = mismatches + 1;
      $display("wrong value at %0t: run hung", $time);
      report_and_stop;
   end
endmodule // fpu_flag_set_shadow_save_tb
